// ---- verilog/soft_fail_monitor.sv ----
// Crystal soft-fail monitor with APB register access.
// Assumes one 20 MHz clock and a measurement strobe every 250 ms.
// What this block does
// - Film selects sensor 1 or 2, default 1
// - Primary and backup correction factors, default 100%
// - Primary factor change rescales thickness, unless a measurement adds thickness that cycle
// - Checks only while crystal in 5-6 MHz band
// - Per-sample rise over limit fails crystal
// - Rise limits 1-24 rejected; zero disables
// - Accumulated layer rise over limit fails crystal
// - Failure: switch backup, open-loop finish, or stop
// - No rise checks in removal mode
// - Failure held until new crystal or clear
// - Excursion when deviation exceeds threshold, floored
// - Counter up on excursion, down otherwise, floor zero
// - Counter above limit fails crystal; zero disables
// - Deviation judged each deposit measurement
// - Holdoff four source lags plus transport lag
// - Report delay in pre-deposit and holdoff
// - Source output 1 or 2, locked while running
// - Nonzero pocket drives turret index outputs while running
// - No source power until pocket in position
// - Loop gain 0.01 to 100, default 10
// - Source lag 0.1 to 100 s, default 1
// - Transport lag 0.1 to 100 s, default 1
//
// Our own choices: the address map and the APB slave port.
`include "soft_fail_params.svh"
module soft_fail_monitor (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Measurement strobe from the oscillator logic
  input  wire logic        meas_valid,
  // Turret pin
  input  wire logic        pocket_in_position,
  // Sensor and source side
  output logic             sensor_sel,
  output logic             backup_relay,
  output logic             source_sel,
  output logic [7:0]       turret_index,
  output logic             source_power_en,
  output logic             open_loop,
  output logic             crystal_failed,
  output logic             count_delay
);
  import soft_fail_pkg::*;

  typedef struct packed {
    layer_state_t st;
    logic [7:0]   film;
    logic [7:0]   pocket;
    logic         removal;
    logic [15:0]  corr1;
    logic [15:0]  corr2;
    logic [15:0]  rise_single;
    logic [15:0]  rise_total;
    logic [7:0]   dev_pct;
    logic [7:0]   dev_limit;
    logic [15:0]  gain;
    logic [15:0]  tau;
    logic [15:0]  dead;
    logic [31:0]  freq;
    logic [31:0]  prev_freq;
    logic         have_prev;
    logic [15:0]  rate_meas;
    logic [15:0]  rate_prog;
    logic [31:0]  rise_acc;
    logic [31:0]  thick;
    logic [7:0]   dev_cnt;
    logic [15:0]  hold_cnt;
    logic         failed;
    logic         on_backup;
    logic [1:0]   pos_sync;
    logic         pos_ok;
    logic [31:0]  rdata;
    logic         err;
  } state_t;

  state_t s_reg;
  state_t s_next;
  logic   excursion;
  logic   wr;
  logic   rd;
  logic   in_band;
  logic   rise_fail;
  logic   dev_fail;
  logic   running;
  logic [31:0] rise;
  logic [31:0] rise_sum;
  logic [15:0] corr_act;

  // ===========================================================
  // Limit check helper
  function automatic logic in_range(input logic [15:0] v,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  // Rise limit legal: zero or within span
  function automatic logic rise_ok(input logic [15:0] v);
    rise_ok = (v == 16'h0000) || in_range(v, `RISE_MIN, `RISE_MAX);
  endfunction

  // Holdoff count in measurements from 0.1 s lags
  function automatic logic [15:0] holdoff(input logic [15:0] t,
                                          input logic [15:0] d);
    logic [31:0] ms;
    ms = (32'd4 * 32'(t) + 32'(d)) * `LAG_UNIT_MS;
    holdoff = 16'((ms + `MEAS_MS - 1) / `MEAS_MS);
  endfunction

  deviation_check u_dev (
    .rate_meas (s_reg.rate_meas),
    .rate_prog (s_reg.rate_prog),
    .pct       (s_reg.dev_pct),
    .excursion (excursion)
  );

  // ===========================================================
  // Decode and checks
  always_comb begin
    wr = psel && penable && pwrite;
    rd = psel && !penable && !pwrite;
    running = (s_reg.st != ST_IDLE) && (s_reg.st != ST_STOP);
    in_band = (s_reg.freq >= `BAND_LO_HZ) &&
              (s_reg.freq <= `BAND_HI_HZ);
    rise = (s_reg.have_prev && s_reg.freq > s_reg.prev_freq) ?
           s_reg.freq - s_reg.prev_freq : 32'h0;
    rise_sum = s_reg.rise_acc + rise;
    rise_fail = !s_reg.removal && in_band &&
                (((s_reg.rise_single != 16'h0) &&
                  (rise > {16'h0, s_reg.rise_single})) ||
                 ((s_reg.rise_total != 16'h0) &&
                  (rise_sum > {16'h0, s_reg.rise_total})));
    dev_fail = in_band && (s_reg.dev_limit != 8'h00) &&
               (s_reg.dev_cnt > s_reg.dev_limit);
    corr_act = s_reg.on_backup ? s_reg.corr2 : s_reg.corr1;
  end

  // ===========================================================
  // Next state
  always_comb begin
    s_next = s_reg;
    s_next.err = 1'b0;
    s_next.pos_sync = {s_reg.pos_sync[0], pocket_in_position};
    s_next.pos_ok = s_reg.pos_sync[1];
    // Register writes
    if (wr && pstrb != 4'h0) begin
      case (paddr)
        `OFF_CTRL: begin
          if (pwdata[`CTRL_START] && !running) begin
            s_next.st = ST_PRE;
            s_next.rise_acc = 32'h0;
            s_next.have_prev = 1'b0;
            s_next.dev_cnt = 8'h00;
            s_next.thick = 32'h0;
          end
          if (pwdata[`CTRL_DEPOSIT] && s_reg.st == ST_PRE) begin
            s_next.st = ST_HOLDOFF;
            s_next.hold_cnt = holdoff(s_reg.tau, s_reg.dead);
          end
          if (pwdata[`CTRL_STOP]) begin
            s_next.st = ST_IDLE;
          end
          if (pwdata[`CTRL_CLEAR] || pwdata[`CTRL_NEWXTAL]) begin
            s_next.failed = 1'b0;
            s_next.dev_cnt = 8'h00;
            s_next.rise_acc = 32'h0;
            s_next.have_prev = 1'b0;
            if (pwdata[`CTRL_NEWXTAL]) begin
              s_next.on_backup = 1'b0;
            end
          end
          s_next.removal = pwdata[`CTRL_REMOVAL];
        end
        `OFF_FILM: begin
          if (!running) begin
            s_next.film = pwdata[7:0];
            s_next.pocket = pwdata[15:8];
          end else begin
            s_next.err = 1'b1;
          end
        end
        `OFF_CORR: begin
          if (pwdata[15:0] != 16'h0 && pwdata[31:16] != 16'h0) begin
            // Rescale thickness by new over old primary factor
            s_next.thick = 32'((64'(s_reg.thick) * 64'(pwdata[15:0]))
                               / 64'(s_reg.corr1));
            s_next.corr1 = pwdata[15:0];
            s_next.corr2 = pwdata[31:16];
          end else begin
            s_next.err = 1'b1;
          end
        end
        `OFF_RISE: begin
          if (rise_ok(pwdata[15:0]) && rise_ok(pwdata[31:16])) begin
            s_next.rise_single = pwdata[15:0];
            s_next.rise_total = pwdata[31:16];
          end else begin
            s_next.err = 1'b1;
          end
        end
        `OFF_DEV: begin
          if (pwdata[7:0] <= `DEV_PCT_MAX &&
              pwdata[15:8] <= `DEV_CNT_MAX) begin
            s_next.dev_pct = pwdata[7:0];
            s_next.dev_limit = pwdata[15:8];
            s_next.rate_prog = pwdata[31:16];
          end else begin
            s_next.err = 1'b1;
          end
        end
        `OFF_LOOP: begin
          if (in_range(pwdata[15:0], `GAIN_MIN, `GAIN_MAX)) begin
            s_next.gain = pwdata[15:0];
          end else begin
            s_next.err = 1'b1;
          end
        end
        `OFF_LAG: begin
          if (in_range(pwdata[15:0], `LAG_MIN, `LAG_MAX) &&
              in_range(pwdata[31:16], `LAG_MIN, `LAG_MAX)) begin
            s_next.tau = pwdata[15:0];
            s_next.dead = pwdata[31:16];
          end else begin
            s_next.err = 1'b1;
          end
        end
        `OFF_MEAS_FREQ: s_next.freq = pwdata;
        `OFF_MEAS_RATE: s_next.rate_meas = pwdata[15:0];
        `OFF_STATUS, `OFF_THICK, `OFF_DEVCNT: s_next.err = 1'b1;
        default: s_next.err = 1'b1;
      endcase
    end
    // Per measurement work on the 250 ms cadence
    if (meas_valid && running) begin
      s_next.prev_freq = s_reg.freq;
      s_next.have_prev = 1'b1;
      if (!s_reg.removal) begin
        s_next.rise_acc = rise_sum;
      end
      if (s_reg.st == ST_DEPOSIT || s_reg.st == ST_OPEN) begin
        s_next.thick = s_reg.thick + 32'(
          (32'(s_reg.rate_meas) * 32'(corr_act)) / 32'd1000);
      end
      case (s_reg.st)
        ST_HOLDOFF: begin
          if (s_reg.hold_cnt <= 16'h0001) begin
            s_next.st = ST_DEPOSIT;
          end else begin
            s_next.hold_cnt = s_reg.hold_cnt - 16'h0001;
          end
        end
        ST_DEPOSIT: begin
          if (excursion) begin
            s_next.dev_cnt = (s_reg.dev_cnt == 8'hFF) ? 8'hFF :
                             s_reg.dev_cnt + 8'h01;
          end else if (s_reg.dev_cnt != 8'h00) begin
            s_next.dev_cnt = s_reg.dev_cnt - 8'h01;
          end
        end
        default: ;
      endcase
    end
    // Failure reaction
    if (running && s_reg.st != ST_OPEN && !s_reg.failed &&
        (rise_fail || dev_fail)) begin
      s_next.dev_cnt = 8'h00;
      s_next.rise_acc = 32'h0;
      s_next.have_prev = 1'b0;
      if (s_reg.film[`FILM_BACKUP] && !s_reg.on_backup) begin
        s_next.on_backup = 1'b1;
      end else begin
        s_next.failed = 1'b1;
        if (s_reg.film[`FILM_OPENLOOP] && s_reg.st == ST_DEPOSIT) begin
          s_next.st = ST_OPEN;
        end else begin
          s_next.st = ST_STOP;
        end
      end
    end
    // Read data captured in setup
    s_next.rdata = 32'h0;
    if (rd) begin
      case (paddr)
        `OFF_FILM: s_next.rdata = {16'h0, s_reg.pocket, s_reg.film};
        `OFF_CORR: s_next.rdata = {s_reg.corr2, s_reg.corr1};
        `OFF_RISE: s_next.rdata = {s_reg.rise_total, s_reg.rise_single};
        `OFF_DEV:  s_next.rdata = {s_reg.rate_prog, s_reg.dev_limit,
                                   s_reg.dev_pct};
        `OFF_LOOP: s_next.rdata = {16'h0, s_reg.gain};
        `OFF_LAG:  s_next.rdata = {s_reg.dead, s_reg.tau};
        `OFF_MEAS_FREQ: s_next.rdata = s_reg.freq;
        `OFF_MEAS_RATE: s_next.rdata = {16'h0, s_reg.rate_meas};
        `OFF_STATUS: s_next.rdata = {24'h0, s_reg.removal, s_reg.on_backup,
                                     count_delay, s_reg.failed, 1'b0,
                                     s_reg.st};
        `OFF_THICK:  s_next.rdata = s_reg.thick;
        `OFF_DEVCNT: s_next.rdata = {24'h0, s_reg.dev_cnt};
        default: s_next.rdata = 32'h0;
      endcase
    end
  end

  // ===========================================================
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
      s_reg.st <= ST_IDLE;
      s_reg.corr1 <= `CORR_RESET;
      s_reg.corr2 <= `CORR_RESET;
      s_reg.gain <= `GAIN_RESET;
      s_reg.tau <= `LAG_RESET;
      s_reg.dead <= `LAG_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // ===========================================================
  // Outputs
  assign prdata = s_reg.rdata;
  assign pready = 1'b1;
  assign pslverr = s_next.err; // Refusal shown in the access phase itself
  assign sensor_sel = s_reg.film[`FILM_SENSOR] ^ s_reg.on_backup;
  assign backup_relay = s_reg.on_backup;
  assign source_sel = s_reg.film[`FILM_SOURCE];
  assign turret_index = running ? s_reg.pocket : 8'h00;
  assign source_power_en = running && s_reg.st != ST_STOP &&
                           (s_reg.pocket == 8'h00 || s_reg.pos_ok);
  assign open_loop = (s_reg.st == ST_OPEN);
  assign crystal_failed = s_reg.failed;
  assign count_delay = (s_reg.st == ST_PRE) ||
                       (s_reg.st == ST_HOLDOFF);
endmodule

// ---- verilog/soft_fail_params.svh ----
// Constants for the crystal soft-fail monitor: offsets, fields, resets, times.
// Assumes inclusion by bare name from the design modules and the bench files.
`ifndef SOFT_FAIL_PARAMS_SVH
`define SOFT_FAIL_PARAMS_SVH
// ===========================================================
// Register byte offsets
`define OFF_CTRL        12'h000
`define OFF_FILM        12'h004
`define OFF_CORR        12'h008
`define OFF_RISE        12'h00C
`define OFF_DEV         12'h010
`define OFF_LOOP        12'h014
`define OFF_LAG         12'h018
`define OFF_MEAS_FREQ   12'h01C
`define OFF_MEAS_RATE   12'h020
`define OFF_STATUS      12'h024
`define OFF_THICK       12'h028
`define OFF_DEVCNT      12'h02C
// ===========================================================
// Control bits (write 1 pulses; removal is a level set by each control write)
`define CTRL_START      0
`define CTRL_DEPOSIT    1
`define CTRL_STOP       2
`define CTRL_CLEAR      3
`define CTRL_NEWXTAL    4
`define CTRL_REMOVAL    5
// Film bits
`define FILM_SENSOR     0
`define FILM_SOURCE     1
`define FILM_OPENLOOP   2
`define FILM_BACKUP     3
`define FILM_POCKET_LSB 8
// ===========================================================
// Reset values and limits (correction in 0.1 %, gain in 0.01, lags in 0.1 s)
`define CORR_RESET      16'h03E8
`define GAIN_RESET      16'h03E8
`define LAG_RESET       16'h000A
`define RISE_MIN        16'h0019
`define RISE_MAX        16'h270F
`define DEV_PCT_MAX     8'h63
`define DEV_CNT_MAX     8'h63
`define GAIN_MIN        16'h0001
`define GAIN_MAX        16'h2710
`define LAG_MIN         16'h0001
`define LAG_MAX         16'h03E8
// Crystal band in Hz
`define BAND_LO_HZ      32'h004C4B40
`define BAND_HI_HZ      32'h005B8D80
// Rate floor, 0.5 A/s in 0.1 A/s units
`define RATE_FLOOR      16'h0005
// Holdoff in measurements per 0.1 s lag: 250 ms cadence, 4 per second
`define MEAS_MS         250
`define LAG_UNIT_MS     100
`endif

// ---- verilog/soft_fail_pkg.sv ----
// Types for the crystal soft-fail monitor.
// Assumes the params header sits beside it.
package soft_fail_pkg;
  // ===========================================================
  // Layer sequencing states, Gray along the usual path
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_PRE     = 3'b001,
    ST_HOLDOFF = 3'b011,
    ST_DEPOSIT = 3'b010,
    ST_OPEN    = 3'b110,
    ST_STOP    = 3'b100
  } layer_state_t;
endpackage

// ---- verilog/deviation_check.sv ----
// Rate deviation judge for one measurement.
// Assumes rates in 0.1 A/s and the threshold in whole percent.
`include "soft_fail_params.svh"
module deviation_check (
  // Measured and programmed rates
  input  wire logic [15:0] rate_meas,
  input  wire logic [15:0] rate_prog,
  // Threshold in percent, zero disables
  input  wire logic [7:0]  pct,
  // Result
  output logic             excursion
);
  logic [15:0] diff;
  logic [23:0] lim;
  logic [23:0] floor_lim;
  // ===========================================================
  // Absolute deviation against percent of rate, floored
  always_comb begin
    diff = (rate_meas > rate_prog) ? rate_meas - rate_prog
                                   : rate_prog - rate_meas;
    lim = 24'((32'(rate_prog) * 32'(pct)) / 32'd100);
    floor_lim = {8'h00, `RATE_FLOOR};
    if (lim < floor_lim) begin
      lim = floor_lim;
    end
    excursion = (pct != 8'h00) && ({8'h00, diff} > lim);
  end
endmodule

// ---- bench/turret_model.sv ----
// Turret model: moves to the asked pocket, then reports it in place.
// Assumes turret_index is held while that pocket is wanted.
module turret_model (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Pocket request, move speed and answer
  input  wire logic [7:0] turret_index,
  input  wire logic       slow,
  output logic            pocket_in_position
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] want;
  int         left;
  // Restart the move on each new pocket; pin low while moving
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      want <= 8'h00;
      left <= 0;
      pocket_in_position <= 1'b0;
    end else if (turret_index != want) begin
      want <= turret_index;
      left <= slow ? 40 : 3;
      pocket_in_position <= 1'b0;
    end else if (left > 0) begin
      left <= left - 1;
    end else begin
      pocket_in_position <= (want != 8'h00);
    end
  end
endmodule

// ---- bench/soft_fail_chk.sv ----
// Port checker for the soft-fail monitor, bound to its top.
// Assumes the params header and the single pclk domain.
`include "soft_fail_params.svh"
module soft_fail_chk (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Register bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pslverr,
  // Sensor, source and turret
  input wire logic        pocket_in_position,
  input wire logic [7:0]  turret_index,
  input wire logic        source_power_en,
  input wire logic        sensor_sel,
  input wire logic        backup_relay,
  input wire logic        source_sel,
  input wire logic        crystal_failed,
  input wire logic        count_delay
);
  logic wr;
  logic clr_wr;
  logic film_wr;
  // Decoded register writes
  assign wr = psel && penable && pwrite && (pstrb != 4'h0);
  assign clr_wr = wr && paddr == `OFF_CTRL
                  && (pwdata[`CTRL_CLEAR] || pwdata[`CTRL_NEWXTAL]);
  assign film_wr = wr && paddr == `OFF_FILM;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========
  // Assertions
  power_hold_a: assert property (
    (turret_index != 8'h00 && !pocket_in_position) [*4]
    |-> !source_power_en) else $error("power without pocket");
  fail_hold_a: assert property (
    $fell(crystal_failed) |-> $past(clr_wr))
    else $error("failure dropped without clear");
  fail_state_a: assert property (
    $rose(crystal_failed) |-> !count_delay)
    else $error("failure kept delay state");
  sensor_chg_a: assert property (
    $changed(sensor_sel) |-> $changed(backup_relay) || $past(film_wr))
    else $error("sensor changed by itself");
  source_chg_a: assert property (
    $changed(source_sel) |-> $past(film_wr) && !$past(count_delay))
    else $error("source changed while running");
  source_lock_a: assert property (
    film_wr && count_delay |-> pslverr)
    else $error("film write taken while running");
  rise_refuse_a: assert property (
    wr && paddr == `OFF_RISE && pwdata[15:0] inside {[16'h0001:16'h0018]}
    |-> pslverr) else $error("rise limit below 25 taken");
  cnt_refuse_a: assert property (
    wr && paddr == `OFF_DEV && pwdata[15:8] > `DEV_CNT_MAX |-> pslverr)
    else $error("count limit above 99 taken");
endmodule

bind soft_fail_monitor soft_fail_chk soft_fail_chk_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .pslverr(pslverr), .pocket_in_position(pocket_in_position),
  .turret_index(turret_index), .source_power_en(source_power_en),
  .sensor_sel(sensor_sel), .backup_relay(backup_relay),
  .source_sel(source_sel), .crystal_failed(crystal_failed),
  .count_delay(count_delay)
);

// ---- bench/crystal_soft_fail_monitor_tb.sv ----
// Testbench: APB master, measurement strobes, turret model.
// Assumes the params header, turret model and bound checker.
`include "soft_fail_params.svh"
module crystal_soft_fail_monitor_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, meas_valid, slow;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic        pready, pslverr, pocket_in_position, sensor_sel;
  logic        backup_relay, source_sel, source_power_en, open_loop;
  logic        crystal_failed, count_delay;
  logic [7:0]  turret_index;
  int          n_mismatch, total_checks, cycles;

  soft_fail_monitor soft_fail_monitor_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .meas_valid(meas_valid),
    .pocket_in_position(pocket_in_position), .sensor_sel(sensor_sel),
    .backup_relay(backup_relay), .source_sel(source_sel),
    .turret_index(turret_index), .source_power_en(source_power_en),
    .open_loop(open_loop), .crystal_failed(crystal_failed),
    .count_delay(count_delay));
  turret_model turret_model_i (.pclk(pclk), .presetn(presetn),
    .turret_index(turret_index), .slow(slow),
    .pocket_in_position(pocket_in_position));

  // Clock and hang limit
  always #25 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  // ==========
  // Shared tasks
  task automatic chk(input string w, input logic [31:0] s, e);
    total_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic chb(input string w, input logic s, e);
    chk(w, {31'h0, s}, {31'h0, e});
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    chb("pslverr", pslverr, 1'b0);
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic e);
    psel <= 1'b1;
    pwrite <= 1'b1;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    chb("pslverr", pslverr, e);
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    psel <= 1'b1;
    pwrite <= 1'b0;
    paddr <= a;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    chk("prdata", prdata, e);
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  task automatic meas(input int n);
    repeat (n) begin
      meas_valid <= 1'b1;
      @(posedge pclk);
      meas_valid <= 1'b0;
      repeat (3) @(posedge pclk);
    end
  endtask
  task automatic do_reset();
    presetn <= 1'b0;
    slow <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask

  // ==========
  // Scenarios
  task automatic t_limits();
    do_reset();
    rdc(`OFF_CORR, 32'h03E803E8);
    rdc(`OFF_LOOP, 32'h000003E8);
    rdc(`OFF_LAG, 32'h000A000A);
    chb("sensor", sensor_sel, 1'b0);
    wr(`OFF_RISE, 32'h00000018, 1'b1);
    wr(`OFF_RISE, 32'h00180000, 1'b1);
    wr(`OFF_RISE, 32'h270F0019, 1'b0);
    wr(`OFF_DEV, 32'h00000064, 1'b1);
    wr(`OFF_DEV, 32'h00006400, 1'b1);
    wr(`OFF_LOOP, 32'h00002711, 1'b1);
    wr(`OFF_LAG, 32'h000A0000, 1'b1);
    wr(`OFF_LAG, 32'h03E9000A, 1'b1);
    wr(`OFF_CORR, 32'h00000000, 1'b1);
    wr(`OFF_STATUS, 32'h00000000, 1'b1);
    wr(12'h100, 32'h00000000, 1'b1);
    rdc(12'h100, 32'h00000000);
    rdc(`OFF_RISE, 32'h270F0019);
    $display("t_limits done");
  endtask
  task automatic t_source();
    do_reset();
    slow <= 1'b1;
    wr(`OFF_FILM, 32'h00000303, 1'b0);
    chb("sensor", sensor_sel, 1'b1);
    wr(`OFF_CTRL, 32'h00000001, 1'b0);
    chk("turret", {24'h0, turret_index}, 32'h3);
    chb("delay", count_delay, 1'b1);
    repeat (20) @(posedge pclk);
    chb("power", source_power_en, 1'b0);
    repeat (40) @(posedge pclk);
    chb("power", source_power_en, 1'b1);
    wr(`OFF_FILM, 32'h00000000, 1'b1);
    chb("source", source_sel, 1'b1);
    $display("t_source done");
  endtask
  task automatic t_holdoff();
    do_reset();
    wr(`OFF_LAG, 32'h00020001, 1'b0);
    wr(`OFF_MEAS_RATE, 32'h00000064, 1'b0);
    wr(`OFF_CTRL, 32'h00000001, 1'b0);
    rdc(`OFF_STATUS, 32'h00000021);
    wr(`OFF_CTRL, 32'h00000002, 1'b0);
    meas(2);
    chb("delay", count_delay, 1'b1);
    meas(1);
    rdc(`OFF_STATUS, 32'h00000002);
    meas(2);
    rdc(`OFF_THICK, 32'h000000C8);
    wr(`OFF_CORR, 32'h03E807D0, 1'b0);
    rdc(`OFF_THICK, 32'h00000190);
    meas(1);
    rdc(`OFF_THICK, 32'h00000258);
    $display("t_holdoff done");
  endtask
  task automatic t_rise();
    do_reset();
    wr(`OFF_LAG, 32'h00020001, 1'b0);
    wr(`OFF_FILM, 32'h00000004, 1'b0);
    wr(`OFF_RISE, 32'h00000019, 1'b0);
    wr(`OFF_MEAS_FREQ, 32'h0053EC60, 1'b0);
    wr(`OFF_CTRL, 32'h00000021, 1'b0);
    meas(1);
    wr(`OFF_CTRL, 32'h00000022, 1'b0);
    meas(3);
    wr(`OFF_MEAS_FREQ, 32'h00557300, 1'b0);
    meas(1);
    chb("failed", crystal_failed, 1'b0);
    wr(`OFF_CTRL, 32'h00000000, 1'b0);
    wr(`OFF_MEAS_FREQ, 32'h005D1420, 1'b0);
    meas(1);
    chb("failed", crystal_failed, 1'b0);
    wr(`OFF_MEAS_FREQ, 32'h00557300, 1'b0);
    meas(1);
    wr(`OFF_MEAS_FREQ, 32'h00557319, 1'b0);
    meas(1);
    chb("failed", crystal_failed, 1'b0);
    wr(`OFF_MEAS_FREQ, 32'h00557333, 1'b0);
    meas(1);
    chb("failed", crystal_failed, 1'b1);
    chb("open", open_loop, 1'b1);
    wr(`OFF_CTRL, 32'h00000008, 1'b0);
    chb("failed", crystal_failed, 1'b0);
    $display("t_rise done");
  endtask
  task automatic t_total();
    do_reset();
    wr(`OFF_RISE, 32'h00320000, 1'b0);
    wr(`OFF_MEAS_FREQ, 32'h0053EC60, 1'b0);
    wr(`OFF_CTRL, 32'h00000001, 1'b0);
    meas(1);
    wr(`OFF_MEAS_FREQ, 32'h0053EC7E, 1'b0);
    meas(1);
    chb("failed", crystal_failed, 1'b0);
    wr(`OFF_MEAS_FREQ, 32'h0053EC9C, 1'b0);
    chb("failed", crystal_failed, 1'b1);
    rdc(`OFF_STATUS, 32'h00000014);
    $display("t_total done");
  endtask
  task automatic t_quality();
    do_reset();
    wr(`OFF_LAG, 32'h00020001, 1'b0);
    wr(`OFF_FILM, 32'h00000008, 1'b0);
    wr(`OFF_DEV, 32'h0064020A, 1'b0);
    wr(`OFF_MEAS_FREQ, 32'h0053EC60, 1'b0);
    wr(`OFF_MEAS_RATE, 32'h0000006F, 1'b0);
    wr(`OFF_CTRL, 32'h00000001, 1'b0);
    wr(`OFF_CTRL, 32'h00000002, 1'b0);
    meas(3);
    rdc(`OFF_DEVCNT, 32'h0);
    meas(2);
    rdc(`OFF_DEVCNT, 32'h2);
    wr(`OFF_MEAS_RATE, 32'h0000006E, 1'b0);
    meas(3);
    rdc(`OFF_DEVCNT, 32'h0);
    wr(`OFF_MEAS_RATE, 32'h0000006F, 1'b0);
    meas(2);
    chb("relay", backup_relay, 1'b0);
    meas(1);
    chb("relay", backup_relay, 1'b1);
    chb("sensor", sensor_sel, 1'b1);
    chb("failed", crystal_failed, 1'b0);
    meas(3);
    chb("failed", crystal_failed, 1'b1);
    chb("open", open_loop, 1'b0);
    $display("t_quality done");
  endtask

  // Closing report
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    meas_valid = 1'b0;
    slow = 1'b0;
    t_limits();
    t_source();
    t_holdoff();
    t_rise();
    t_total();
    t_quality();
    give_verdict();
  end
endmodule
